// [core/lsd_defs.vh]
// Constants for the line supervision and debounce block
`ifndef LSD_DEFS_VH
`define LSD_DEFS_VH

`define LSD_ADDR_LINE_STATUS   8'h00
`define LSD_ADDR_CHANNEL_MASK  8'h04
`define LSD_ADDR_THRESH_SEL    8'h08
`define LSD_ADDR_DEBOUNCE_CFG  8'h0C
`define LSD_ADDR_POL_STATUS    8'h10
`define LSD_ADDR_LINE_CONTROL  8'h14
`define LSD_ADDR_THRESH_WORD   8'h18
`define LSD_ADDR_HYST_WORD     8'h1C
`define LSD_ADDR_MODE          8'h20
`define LSD_ADDR_RAMP          8'h24
`define LSD_ADDR_EVENT         8'h28

`define LSD_MASK_OFFHOOK       0
`define LSD_MASK_GROUNDKEY     1
`define LSD_MASK_POLARITY      2
`define LSD_EVT_OFFHOOK        0
`define LSD_EVT_GROUNDKEY      1
`define LSD_EVT_POLARITY       2

// Threshold words are 16-bit codes, 1 LSB = 0.01 mA of loop current
`define LSD_THRESH_DEFAULT     16'h02BC
`define LSD_HYST_DEFAULT       16'h00C8
`define LSD_THRESH_SEL_RESET   1'b1
`define LSD_DEBOUNCE_RESET     4'h0
`define LSD_RAMP_RESET         8'h10

`define LSD_CLK_HZ             10000000
`define LSD_STEP_NS            125000
`define LSD_STEP_CYCLES        ((`LSD_CLK_HZ / 1000) * `LSD_STEP_NS / 1000000)
`define LSD_STATES             16
`define LSD_RESP_OKAY          2'b00
`define LSD_RESP_SLVERR        2'b10

`endif

// [core/lsd_debounce.v]
// Per-channel 16-state up/down debounce counter
`timescale 1ns/100ps
`default_nettype none
`include "lsd_defs.vh"
module lsd_debounce (
  input  wire       CLK,
  input  wire       RESET,
  input  wire       tick,
  input  wire       criterion,
  output reg        status
);
  reg  [3:0] count;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      count  <= 4'h0;
      status <= 1'b0;
    end else if (tick) begin
      if (criterion) begin
        if (count != 4'hF) count <= count + 4'h1;
        else status <= 1'b1;
      end else begin
        if (count != 4'h0) count <= count - 4'h1;
        else status <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [core/lsd_prescaler.v]
// Programmable debounce interval tick generator
`timescale 1ns/100ps
`default_nettype none
`include "lsd_defs.vh"
module lsd_prescaler (
  input  wire       CLK,
  input  wire       RESET,
  input  wire [3:0] interval,
  output reg        tick
);
  // Step length in clocks, cut to the counter width on purpose
  localparam integer STEP_FULL = `LSD_STEP_CYCLES;
  localparam [10:0]  STEP      = STEP_FULL[10:0];
  reg  [10:0] cyc;
  reg  [3:0]  steps;

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      cyc   <= 11'h000;
      steps <= 4'h0;
      tick  <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (cyc == STEP - 11'h001) begin
        cyc <= 11'h000;
        if (steps >= interval) begin
          steps <= 4'h0;
          tick  <= 1'b1;
        end else begin
          steps <= steps + 4'h1;
        end
      end else begin
        cyc <= cyc + 11'h001;
      end
    end
  end
endmodule
`default_nettype wire

// [core/lsd_supervision.v]
// Four-channel line supervision with debounce and AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "lsd_defs.vh"
module lsd_supervision (
  input  wire        CLK,
  input  wire        RESET,
  input  wire [7:0]  S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [7:0]  S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire [3:0]  SLEEP_LOOP_SENSE,
  input  wire [63:0] ACTIVE_LOOP_SENSE,
  input  wire [3:0]  LONGITUDINAL_SENSE,
  input  wire [3:0]  LONGITUDINAL_POSITIVE,
  output reg  [3:0]  POLARITY_REVERSE,
  output reg  [7:0]  RAMP_TIME,
  output reg         IRQ
);
  reg  [3:0]  offhook_status;
  reg  [3:0]  groundkey_status;
  reg         groundkey_polarity;
  reg         offhook_irq_mask;
  reg         groundkey_irq_mask;
  reg         polarity_irq_mask;
  reg         threshold_select;
  reg  [3:0]  debounce_interval;
  reg  [15:0] offhook_threshold_word;
  reg  [15:0] offhook_hysteresis_word;
  reg  [3:0]  polarity_reverse_req;
  reg  [7:0]  ramp_word;
  reg         sleep_mode;
  reg  [2:0]  event_flags;
  reg  [3:0]  loop_crit;
  reg  [3:0]  offhook_prev;
  reg  [3:0]  groundkey_prev;
  reg         polarity_prev;
  reg  [7:0]  wr_addr;
  reg  [31:0] wr_data;
  reg  [3:0]  wr_strb;
  reg         have_aw;
  reg         have_w;
  wire        tick;
  wire [3:0]  offhook_db;
  wire [3:0]  groundkey_db;
  wire [15:0] thr_on;
  wire [15:0] hyst_sel;
  wire [15:0] thr_off;
  wire        do_write;
  wire [2:0]  new_events;
  integer     i;

  lsd_prescaler u_prescaler (
    .CLK      (CLK),
    .RESET    (RESET),
    .interval (debounce_interval),
    .tick     (tick)
  );

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
      lsd_debounce u_hook (
        .CLK       (CLK),
        .RESET     (RESET),
        .tick      (tick),
        .criterion (loop_crit[ch]),
        .status    (offhook_db[ch])
      );
      // per-channel ground-key debounce filter; halted in sleep
      lsd_debounce u_gkey (
        .CLK       (CLK),
        .RESET     (RESET),
        .tick      (tick & ~sleep_mode),
        .criterion (LONGITUDINAL_SENSE[ch]),
        .status    (groundkey_db[ch])
      );
    end
  endgenerate

  assign thr_on   = threshold_select ? `LSD_THRESH_DEFAULT : offhook_threshold_word;
  assign hyst_sel = threshold_select ? `LSD_HYST_DEFAULT : offhook_hysteresis_word;
  assign thr_off  = (hyst_sel > thr_on) ? 16'h0000 : thr_on - hyst_sel;

  // Active-mode criterion keeps hysteresis relative to the debounced state; in sleep it is SLEEP_LOOP_SENSE as is
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      loop_crit <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (sleep_mode) begin
          loop_crit[i] <= SLEEP_LOOP_SENSE[i];
        end else if (offhook_status[i]) begin
          loop_crit[i] <= ACTIVE_LOOP_SENSE[i*16 +: 16] >= thr_off;
        end else begin
          loop_crit[i] <= ACTIVE_LOOP_SENSE[i*16 +: 16] > thr_on;
        end
      end
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      offhook_status     <= 4'h0;
      groundkey_status   <= 4'h0;
      groundkey_polarity <= 1'b0;
    end else begin
      offhook_status <= offhook_db;
      if (!sleep_mode) begin
        groundkey_status   <= groundkey_db;
        groundkey_polarity <= |(LONGITUDINAL_POSITIVE & groundkey_db);
      end
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      offhook_prev   <= 4'h0;
      groundkey_prev <= 4'h0;
      polarity_prev  <= 1'b0;
    end else begin
      offhook_prev   <= offhook_status;
      groundkey_prev <= groundkey_status;
      polarity_prev  <= groundkey_polarity;
    end
  end

  assign new_events[`LSD_EVT_OFFHOOK]   = |(offhook_status ^ offhook_prev);
  assign new_events[`LSD_EVT_GROUNDKEY] = |(groundkey_status & ~groundkey_prev);
  assign new_events[`LSD_EVT_POLARITY]  = groundkey_polarity ^ polarity_prev;

  assign do_write = have_aw & have_w & ~S_AXI_BVALID;

  // AXI write channel: address and data accepted in either order
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= `LSD_RESP_OKAY;
      have_aw       <= 1'b0;
      have_w        <= 1'b0;
      wr_addr       <= 8'h00;
      wr_data       <= 32'h00000000;
      wr_strb       <= 4'h0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        wr_addr       <= S_AXI_AWADDR;
        have_aw       <= 1'b1;
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wr_data      <= S_AXI_WDATA;
        wr_strb      <= S_AXI_WSTRB;
        have_w       <= 1'b1;
        S_AXI_WREADY <= 1'b0;
      end
      if (do_write) begin
        have_aw      <= 1'b0;
        have_w       <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        case (wr_addr)
          `LSD_ADDR_CHANNEL_MASK, `LSD_ADDR_THRESH_SEL, `LSD_ADDR_DEBOUNCE_CFG,
          `LSD_ADDR_LINE_CONTROL, `LSD_ADDR_THRESH_WORD, `LSD_ADDR_HYST_WORD,
          `LSD_ADDR_MODE, `LSD_ADDR_RAMP, `LSD_ADDR_EVENT:
            S_AXI_BRESP <= `LSD_RESP_OKAY;
          default:
            S_AXI_BRESP <= `LSD_RESP_SLVERR;
        endcase
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  // Control registers; strobe lane 0 carries every field of 8 bits or less
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      offhook_irq_mask        <= 1'b0;
      groundkey_irq_mask      <= 1'b0;
      polarity_irq_mask       <= 1'b0;
      threshold_select        <= `LSD_THRESH_SEL_RESET;
      debounce_interval       <= `LSD_DEBOUNCE_RESET;
      offhook_threshold_word  <= `LSD_THRESH_DEFAULT;
      offhook_hysteresis_word <= `LSD_HYST_DEFAULT;
      polarity_reverse_req    <= 4'h0;
      ramp_word               <= `LSD_RAMP_RESET;
      sleep_mode              <= 1'b0;
    end else if (do_write) begin
      case (wr_addr)
        `LSD_ADDR_CHANNEL_MASK: if (wr_strb[0]) begin
          offhook_irq_mask   <= wr_data[`LSD_MASK_OFFHOOK];
          groundkey_irq_mask <= wr_data[`LSD_MASK_GROUNDKEY];
          polarity_irq_mask  <= wr_data[`LSD_MASK_POLARITY];
        end
        `LSD_ADDR_THRESH_SEL:   if (wr_strb[0]) threshold_select <= wr_data[0];
        `LSD_ADDR_DEBOUNCE_CFG: if (wr_strb[0]) debounce_interval <= wr_data[3:0];
        `LSD_ADDR_LINE_CONTROL: if (wr_strb[0]) polarity_reverse_req <= wr_data[3:0];
        `LSD_ADDR_THRESH_WORD: begin
          if (wr_strb[0]) offhook_threshold_word[7:0]  <= wr_data[7:0];
          if (wr_strb[1]) offhook_threshold_word[15:8] <= wr_data[15:8];
        end
        `LSD_ADDR_HYST_WORD: begin
          if (wr_strb[0]) offhook_hysteresis_word[7:0]  <= wr_data[7:0];
          if (wr_strb[1]) offhook_hysteresis_word[15:8] <= wr_data[15:8];
        end
        `LSD_ADDR_MODE:         if (wr_strb[0]) sleep_mode <= wr_data[0];
        `LSD_ADDR_RAMP:         if (wr_strb[0]) ramp_word <= wr_data[7:0];
        default: ;
      endcase
    end
  end

  // Sticky events; a new event wins over a same-cycle clear (write 1 to clear)
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      event_flags <= 3'h0;
    end else if (do_write && wr_addr == `LSD_ADDR_EVENT && wr_strb[0]) begin
      event_flags <= (event_flags & ~wr_data[2:0]) | new_events;
    end else begin
      event_flags <= event_flags | new_events;
    end
  end

  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      IRQ              <= 1'b0;
      POLARITY_REVERSE <= 4'h0;
      RAMP_TIME        <= `LSD_RAMP_RESET;
    end else begin
      IRQ <= (event_flags[`LSD_EVT_OFFHOOK]   & ~offhook_irq_mask) |
             (event_flags[`LSD_EVT_GROUNDKEY] & ~groundkey_irq_mask) |
             (event_flags[`LSD_EVT_POLARITY]  & ~polarity_irq_mask);
      // reversal with ramp; held in sleep
      if (!sleep_mode) begin
        POLARITY_REVERSE <= polarity_reverse_req;
        RAMP_TIME        <= ramp_word;
      end
    end
  end

  // AXI read channel, one read at a time, answer one cycle after address
  always @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= `LSD_RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b1;
      S_AXI_RRESP   <= `LSD_RESP_OKAY;
      case (S_AXI_ARADDR)
        `LSD_ADDR_LINE_STATUS:  S_AXI_RDATA <= {24'h000000, groundkey_status, offhook_status};
        `LSD_ADDR_CHANNEL_MASK: S_AXI_RDATA <= {29'h00000000, polarity_irq_mask,
                                                groundkey_irq_mask, offhook_irq_mask};
        `LSD_ADDR_THRESH_SEL:   S_AXI_RDATA <= {31'h00000000, threshold_select};
        `LSD_ADDR_DEBOUNCE_CFG: S_AXI_RDATA <= {28'h0000000, debounce_interval};
        `LSD_ADDR_POL_STATUS:   S_AXI_RDATA <= {31'h00000000, groundkey_polarity};
        `LSD_ADDR_LINE_CONTROL: S_AXI_RDATA <= {28'h0000000, polarity_reverse_req};
        `LSD_ADDR_THRESH_WORD:  S_AXI_RDATA <= {16'h0000, offhook_threshold_word};
        `LSD_ADDR_HYST_WORD:    S_AXI_RDATA <= {16'h0000, offhook_hysteresis_word};
        `LSD_ADDR_MODE:         S_AXI_RDATA <= {31'h00000000, sleep_mode};
        `LSD_ADDR_RAMP:         S_AXI_RDATA <= {24'h000000, ramp_word};
        `LSD_ADDR_EVENT:        S_AXI_RDATA <= {29'h00000000, event_flags};
        default: begin
          S_AXI_RDATA <= 32'h00000000;
          S_AXI_RRESP <= `LSD_RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID  <= 1'b0;
      S_AXI_ARREADY <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [test/lsd_supervision_asserts.sv]
// Bus and control checks for the line supervision block
`timescale 1ns/100ps
`default_nettype none
`include "lsd_defs.vh"
module lsd_asserts (
  input wire logic        CLK,
  input wire logic        RESET,
  input wire logic        S_AXI_AWVALID,
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WVALID,
  input wire logic        S_AXI_WREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic        S_AXI_ARVALID,
  input wire logic        S_AXI_ARREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic [1:0]  S_AXI_RRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [3:0]  POLARITY_REVERSE,
  input wire logic [7:0]  RAMP_TIME,
  input wire logic        IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  logic [3:0] wcnt;
  // Cycles since the last accepted write word; saturates so it never wraps to a false match
  always @(posedge CLK or posedge RESET) begin
    if (RESET) wcnt <= 4'hF;
    else if (S_AXI_WVALID && S_AXI_WREADY) wcnt <= 4'h0;
    else if (wcnt != 4'hF) wcnt <= wcnt + 4'h1;
  end
  sequence wr_take;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
  endsequence
  sequence rd_take;
    S_AXI_ARVALID && S_AXI_ARREADY;
  endsequence
  wr_answer_a: assert property (wr_take |-> ##[1:2] S_AXI_BVALID)
    else $error("write response late");
  rd_answer_a: assert property (rd_take |=> S_AXI_RVALID)
    else $error("read data late");
  b_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
    S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  r_hold_a: assert property (S_AXI_RVALID && !S_AXI_RREADY |=>
    S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
  wr_busy_a: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
    else $error("write taken while busy");
  rd_busy_a: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
    else $error("read taken while busy");
  err_data_a: assert property (S_AXI_RVALID && S_AXI_RRESP == `LSD_RESP_SLVERR |->
    S_AXI_RDATA == 32'h0)
    else $error("refused read carries data");
  ctl_change_a: assert property (
    !$stable(RAMP_TIME) || !$stable(POLARITY_REVERSE) |-> wcnt <= 4'h2)
    else $error("line control changed without a write");
  irq_fall_a: assert property ($fell(IRQ) |-> wcnt <= 4'h3)
    else $error("interrupt fell without a write");
endmodule
`default_nettype wire

// [test/lsd_line_model.sv]
// Behavioural line interface circuit feeding the sense inputs
`timescale 1ns/100ps
`default_nettype none
module lsd_line_model (
  input  wire logic [0:0]  clk,
  input  wire logic [63:0] want_code,
  input  wire logic [3:0]  want_sleep,
  input  wire logic [3:0]  want_gk,
  input  wire logic [3:0]  want_pos,
  input  wire logic [3:0]  reverse_req,
  output var  logic [3:0]  sleep_sense,
  output var  logic [63:0] active_sense,
  output var  logic [3:0]  long_sense,
  output var  logic [3:0]  long_pos,
  output var  logic [3:0]  tip_ring_rev
);
  // Sense paths settle one clock after the line changes
  always @(posedge clk) begin
    sleep_sense <= want_sleep;
    active_sense <= want_code;
    long_sense <= want_gk;
    long_pos <= want_pos;
    // line voltage follows the reversal request
    tip_ring_rev <= reverse_req;
  end
endmodule
`default_nettype wire

// [test/lsd_supervision_bench.sv]
// Self-checking bench for the line supervision block
`timescale 1ns/100ps
`default_nettype none
`include "lsd_defs.vh"
module lsd_supervision_bench;
  localparam logic [1:0] OK = `LSD_RESP_OKAY;
  localparam logic [1:0] NG = `LSD_RESP_SLVERR;
  logic        clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0]  aw = 8'h0, ar = 8'h0;
  logic [31:0] wd = 32'h0, rnd;
  logic [63:0] code = 64'h0;
  logic [3:0]  slp = 4'h0, gk = 4'h0, pos = 4'h0;
  logic [15:0] hi, lo, mid;
  wire logic        awr, wrd, bv, arr, rv, irq;
  wire logic [1:0]  br, rr;
  wire logic [31:0] rdata;
  wire logic [7:0]  ramp;
  wire logic [63:0] as;
  wire logic [3:0]  rev, ss, ls, lp, trr;
  int          fail_count = 0, num_checks = 0;
  always #50 clk = ~clk;
  lsd_supervision i_lsd_supervision (.CLK(clk), .RESET(rst), .S_AXI_AWADDR(aw),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd), .S_AXI_BRESP(br), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(bry), .S_AXI_ARADDR(ar), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .SLEEP_LOOP_SENSE(ss), .ACTIVE_LOOP_SENSE(as), .LONGITUDINAL_SENSE(ls),
    .LONGITUDINAL_POSITIVE(lp), .POLARITY_REVERSE(rev), .RAMP_TIME(ramp), .IRQ(irq));
  lsd_line_model i_lsd_line_model (.clk(clk), .want_code(code), .want_sleep(slp),
    .want_gk(gk), .want_pos(pos), .reverse_req(rev), .sleep_sense(ss), .active_sense(as),
    .long_sense(ls), .long_pos(lp), .tip_ring_rev(trr));
  task chk(input logic [63:0] got, input logic [63:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task close_out;
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (!bv && n < 40);
    bry <= 1'b0;
    chk({bv, br}, {1'b1, er});
  endtask
  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    ar <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (!rv && n < 40);
    rry <= 1'b0;
    chk({rv, rr, rdata}, {1'b1, er, ed});
  endtask
  // Three debounce phases of about 22000 cycles each fit well inside this limit
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    close_out;
  end
  initial begin
    void'($urandom(32'h8460));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd(`LSD_ADDR_CHANNEL_MASK, 32'h0, OK);
    rd(`LSD_ADDR_THRESH_SEL, 32'h1, OK);
    rd(`LSD_ADDR_DEBOUNCE_CFG, 32'h0, OK);
    rd(`LSD_ADDR_THRESH_WORD, 32'h2BC, OK);
    rd(`LSD_ADDR_HYST_WORD, 32'hC8, OK);
    rd(`LSD_ADDR_RAMP, 32'h10, OK);
    rd(8'h30, 32'h0, NG);
    wr(`LSD_ADDR_LINE_STATUS, 32'hFF, NG);
    wr(`LSD_ADDR_POL_STATUS, 32'h1, NG);
    wr(`LSD_ADDR_DEBOUNCE_CFG, 32'hF, OK);
    rd(`LSD_ADDR_DEBOUNCE_CFG, 32'hF, OK);
    wr(`LSD_ADDR_DEBOUNCE_CFG, 32'h0, OK);
    rnd = $urandom;
    wr(`LSD_ADDR_RAMP, {24'h0, rnd[23:16]}, OK);
    wr(`LSD_ADDR_LINE_CONTROL, {28'h0, rnd[27:24]}, OK);
    // The line model follows the reversal output one clock later
    repeat (2) @(posedge clk);
    chk({ramp, rev, trr}, {rnd[23:16], rnd[27:24], rnd[27:24]});
    hi = 16'h02BD + {8'h0, rnd[7:0]};
    // At or above the programmed lower level 0x180, below the fixed one 0x1F4
    lo = 16'h0180 + {10'h0, rnd[13:8]};
    // Above the fixed threshold, not above the programmed 0x300
    mid = 16'h02BD + {10'h0, rnd[31:26]};
    // Channel 1 held off-hook, channel 0 only briefly, ground key on channel 2
    code <= {32'h0, hi, hi};
    gk <= 4'h4;
    pos <= 4'h4;
    repeat (5000) @(posedge clk);
    code <= {32'h0, hi, 16'h0};
    repeat (12500) @(posedge clk);
    rd(`LSD_ADDR_LINE_STATUS, 32'h0, OK);
    repeat (4500) @(posedge clk);
    rd(`LSD_ADDR_LINE_STATUS, 32'h42, OK);
    rd(`LSD_ADDR_POL_STATUS, 32'h1, OK);
    rd(`LSD_ADDR_EVENT, 32'h7, OK);
    chk(irq, 1'b1);
    // Programmed levels 0x300 and 0x180 replace the fixed ones
    wr(`LSD_ADDR_THRESH_WORD, 32'h300, OK);
    wr(`LSD_ADDR_HYST_WORD, 32'h180, OK);
    wr(`LSD_ADDR_THRESH_SEL, 32'h0, OK);
    rd(`LSD_ADDR_HYST_WORD, 32'h180, OK);
    // Channel 1 into the programmed band, channel 0 below the programmed 0x300, ground key released
    wr(`LSD_ADDR_EVENT, 32'h7, OK);
    code <= {32'h0, lo, mid};
    gk <= 4'h0;
    repeat (22000) @(posedge clk);
    rd(`LSD_ADDR_LINE_STATUS, 32'h2, OK);
    rd(`LSD_ADDR_POL_STATUS, 32'h0, OK);
    rd(`LSD_ADDR_EVENT, 32'h4, OK);
    chk(irq, 1'b1);
    wr(`LSD_ADDR_CHANNEL_MASK, 32'h4, OK);
    rd(`LSD_ADDR_CHANNEL_MASK, 32'h4, OK);
    chk(irq, 1'b0);
    // Sleep: only the sleep loop sense counts, ground key stays frozen
    wr(`LSD_ADDR_MODE, 32'h1, OK);
    wr(`LSD_ADDR_CHANNEL_MASK, 32'h7, OK);
    wr(`LSD_ADDR_EVENT, 32'h7, OK);
    slp <= 4'h8;
    gk <= 4'h1;
    pos <= 4'h1;
    repeat (22000) @(posedge clk);
    rd(`LSD_ADDR_LINE_STATUS, 32'h8, OK);
    rd(`LSD_ADDR_POL_STATUS, 32'h0, OK);
    rd(`LSD_ADDR_EVENT, 32'h1, OK);
    chk(irq, 1'b0);
    // Long interval first, so the entry pulse of active mode is filtered out
    wr(`LSD_ADDR_DEBOUNCE_CFG, 32'h7, OK);
    rd(`LSD_ADDR_DEBOUNCE_CFG, 32'h7, OK);
    wr(`LSD_ADDR_MODE, 32'h0, OK);
    close_out;
  end
endmodule
bind lsd_supervision lsd_asserts i_lsd_asserts (.*);
`default_nettype wire
